//--- verif/lead_seq_assertions.sv
// Port checks of the control-lead sequencer
`timescale 1ns/10ps
module lead_seq_assertions import lead_seq_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Modem leads
  input wire logic dcd,
  input wire logic dsr,
  input wire logic dtr,
  // Call indications
  input wire logic call_active,
  input wire logic busy_outbound,
  input wire logic prompt_enable,
  input wire logic menu_enable,
  input wire logic echo_enable,
  input wire logic data_pass,
  input wire logic autobaud_wait
);
  localparam longint RING_MAX = longint'(3502) * longint'(TICK_LEN);
  int ring_q;
  // Cycles spent ringing with no validated carrier
  always_ff @(posedge mclk) begin
    if (!resetn || !call_active || data_pass || prompt_enable) begin
      ring_q <= 0;
    end else begin
      ring_q <= ring_q + 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_quiet; !dcd |=> !menu_enable && !echo_enable; endproperty
  a_quiet: assert property (p_quiet) else $error("menu or echo without carrier");
  property p_out; data_pass |-> !prompt_enable && !busy_outbound; endproperty
  a_out: assert property (p_out) else $error("prompt or busy on outbound call");
  property p_dtr; call_active |-> dtr; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr off during call");
  property p_busy; busy_outbound |-> call_active && !data_pass; endproperty
  a_busy: assert property (p_busy) else $error("busy without inbound call");
  property p_disc; prompt_enable && !(dcd && dsr) |=> !call_active; endproperty
  a_disc: assert property (p_disc) else $error("lost lead did not end call");
  property p_baud; $rose(prompt_enable) |-> autobaud_wait; endproperty
  a_baud: assert property (p_baud) else $error("no autobaud wait on validation");
  property p_ring; ring_q <= RING_MAX; endproperty
  a_ring: assert property (p_ring) else $error("carrier wait overran");
  property p_pass; $rose(data_pass) |-> !$past(call_active); endproperty
  a_pass: assert property (p_pass) else $error("outbound taken while busy");
  c_valid: cover property ($rose(prompt_enable));
  c_out: cover property ($rose(data_pass));
  c_end: cover property ($fell(call_active));
endmodule // lead_seq_assertions

bind lead_sequencer lead_seq_assertions #(.TICK_LEN(TICK_LEN)) chk (.mclk, .resetn, .dcd, .dsr, .dtr,
  .call_active, .busy_outbound, .prompt_enable, .menu_enable, .echo_enable, .data_pass, .autobaud_wait);

//--- verif/modem_model.sv
// Behavioural external modem on the control leads
`timescale 1ns/10ps
module modem_model (
  // Clock
  input wire logic mclk,
  // Bench controls
  input wire logic ring,
  input wire logic dial,
  input wire logic hang,
  input wire logic dsr_off,
  input wire logic [15:0] delay,
  // Control leads
  input wire logic dtr,
  output logic ri,
  output logic dcd,
  output logic dsr
);
  logic carrier_q = 1'b0;
  logic dtr_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  // Ring shown until answered, carrier shown dynamically
  assign ri = ring && !carrier_q;
  assign dcd = carrier_q;
  assign dsr = !dsr_off;
  ////////////////////////////////////////
  // Answer or dial after a delay while DTR is on; DTR off clears everything
  always_ff @(posedge mclk) begin
    dtr_q <= dtr;
    if (hang || (dtr_q && !dtr)) begin
      carrier_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (dtr && (ring || dial) && !carrier_q) begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q == delay) carrier_q <= 1'b1;
    end
  end
endmodule // modem_model

//--- verif/testbench.sv
// Self-checking testbench of the control-lead sequencer
`timescale 1ns/10ps
module testbench import lead_seq_pkg::*;;
  localparam int TL = 10;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, ri, dcd, dsr, dtr, call_active, busy_outbound, prompt_enable;
  logic menu_enable, echo_enable, data_pass, autobaud_wait, hotline_call;
  logic [1:0] baud_select;
  logic dtr_in = 1'b0, ring = 1'b0, dial = 1'b0, hang = 1'b0, dsr_off = 1'b0;
  logic [15:0] delay = 16'h0014;
  int fail_count = 0, cmp_count = 0, n;
  wire logic [7:0] outs = {call_active, 1'b0, prompt_enable, echo_enable, 3'h0, dtr};
  always #5 mclk = ~mclk;
  lead_sequencer #(.TICK_LEN(TL)) dut (.mclk, .resetn, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .ri, .dcd, .dsr, .dtr, .dtr_in, .call_active, .busy_outbound, .prompt_enable,
    .menu_enable, .echo_enable, .data_pass, .autobaud_wait, .hotline_call, .baud_select);
  modem_model modem (.mclk, .ring, .dial, .hang, .dsr_off, .delay, .dtr, .ri, .dcd, .dsr);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) fail_count++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wait_for(input int b, input logic v);
    n = 0;
    while (outs[b] !== v && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    // A wait that runs out counts as a mismatch
    if (outs[b] !== v) fail_count++;
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    bus(0, MODE_OFS, 0);
    check(rd, 32'h0);
    bus(1, MODE_OFS, 32'h3F);
    bus(0, MODE_OFS, 0);
    check(rd, 32'h3F);
    bus(0, 4'h2, 0);
    check(rd, 32'h0);
  endtask
  task automatic t_in;
    bus(1, MODE_OFS, 32'h0);
    check(dtr, 1'b0);
    ring <= 1'b1;
    wait_for(7, 1'b1);
    check({dtr, busy_outbound}, 2'h3);
    bus(0, STATUS_OFS, 0);
    check(rd, 32'h0000028F);
    wait_for(5, 1'b1);
    check({autobaud_wait, menu_enable, echo_enable}, 3'h7);
    bus(1, CMD_OFS, 32'h4);
    @(posedge mclk);
    check(autobaud_wait, 1'b0);
    ring <= 1'b0;
    hang <= 1'b1;
    wait_for(7, 1'b0);
    hang <= 1'b0;
    check({dtr, busy_outbound}, 2'h0);
    bus(0, EVENT_OFS, 0);
    check(rd[2:0], 3'h6);
    bus(1, EVENT_OFS, 32'h7);
  endtask
  task automatic t_to;
    delay <= 16'hFFFF;
    ring <= 1'b1;
    wait_for(7, 1'b1);
    ring <= 1'b0;
    wait_for(7, 1'b0);
    check(n >= 3499 * TL && n <= 3502 * TL, 1'b1);
    bus(0, EVENT_OFS, 0);
    check(rd[2:0], 3'h1);
    bus(1, EVENT_OFS, 32'h7);
  endtask
  task automatic t_out;
    delay <= 16'h0005;
    bus(1, CMD_OFS, 32'h1);
    @(posedge mclk);
    check({data_pass, dtr, busy_outbound, prompt_enable}, 4'hC);
    dial <= 1'b1;
    wait_for(4, 1'b1);
    check(prompt_enable, 1'b0);
    dsr_off <= 1'b1;
    wait_for(7, 1'b0);
    dial <= 1'b0;
    dsr_off <= 1'b0;
    bus(0, EVENT_OFS, 0);
    check({dtr, rd[2:0]}, 4'h2);
    bus(1, EVENT_OFS, 32'h7);
  endtask
  task automatic t_hot;
    bus(1, MODE_OFS, 32'h21);
    ring <= 1'b1;
    wait_for(7, 1'b1);
    ring <= 1'b0;
    check(hotline_call, 1'b1);
    check(baud_select, 2'h2);
    // Outbound request refused while ringing in a hotline mode
    bus(1, CMD_OFS, 32'h1);
    @(posedge mclk);
    check(data_pass, 1'b0);
    bus(1, MODE_OFS, 32'h0F);
    dtr_in <= 1'b1;
    repeat (3) @(posedge mclk);
    check({call_active, dtr, hotline_call}, 3'h1);
    dtr_in <= 1'b0;
  endtask
  task automatic t_forced;
    bus(1, MODE_OFS, 32'h2);
    repeat (2) @(posedge mclk);
    check(dtr, 1'b1);
    ring <= 1'b1;
    wait_for(5, 1'b1);
    ring <= 1'b0;
    hang <= 1'b1;
    wait_for(0, 1'b0);
    hang <= 1'b0;
    wait_for(0, 1'b1);
    check(n >= 19 * TL && n <= 22 * TL, 1'b1);
    // Slow answer so the modem does not pick up during blanking
    delay <= 16'hFFFF;
    ring <= 1'b1;
    wait_for(7, 1'b1);
    check(n >= 199 * TL && n <= 203 * TL, 1'b1);
    ring <= 1'b0;
    // Mode 3: drop after an established call, then no blanking
    bus(1, CMD_OFS, 32'h2);
    hang <= 1'b1;
    bus(1, MODE_OFS, 32'h3);
    hang <= 1'b0;
    delay <= 16'h0005;
    ring <= 1'b1;
    wait_for(5, 1'b1);
    hang <= 1'b1;
    ring <= 1'b0;
    wait_for(0, 1'b0);
    hang <= 1'b0;
    wait_for(0, 1'b1);
    check(n >= 19 * TL && n <= 22 * TL, 1'b1);
    ring <= 1'b1;
    wait_for(7, 1'b1);
    check(n <= 3, 1'b1);
    ring <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_regs;
    t_in;
    t_to;
    t_out;
    t_hot;
    t_forced;
    tally_and_finish;
  end
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish;
  end
endmodule // testbench

//--- verilog/interval_timer.sv
// Tick-based interval timer used for carrier wait, DTR drop and input blanking
`timescale 1ns/10ps
module interval_timer import lead_seq_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic [TIMER_W-1:0] limit,
  // Result
  output logic expired
);
  localparam int PW = $clog2(TICK_LEN + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_LEN - 1);

  logic [PW-1:0] pre_q;
  logic [TIMER_W-1:0] cnt_q;
  logic run_q;
  logic expired_q;
  wire tick = (pre_q == PRE_LAST);
  wire last = run_q && tick && (cnt_q <= 12'h001);

  assign expired = expired_q;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler restarts with each interval so the full tick count elapses
  always_ff @(posedge mclk) begin
    if (!resetn || start || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Down counter of whole ticks, expiry holds until the next start
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      expired_q <= 1'b0;
    end else if (start) begin
      cnt_q <= limit;
      run_q <= 1'b1;
      expired_q <= 1'b0;
    end else if (last) begin
      run_q <= 1'b0;
      expired_q <= 1'b1;
    end else if (run_q && tick) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // interval_timer

//--- verilog/lead_seq_pkg.sv
// Constants, register map and field layout of the modem control-lead sequencer
package lead_seq_pkg;
  // Clock and timing base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 10000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_MS = 10;
  localparam int CARRIER_WAIT_MS = 35000;
  localparam int DTR_DROP_MS = 200;
  localparam int BLANK_MS = 2000;
  localparam int TIMER_W = 12;
  // Longest waits round down, least times round up
  localparam logic [TIMER_W-1:0] CARRIER_WAIT_TICKS = TIMER_W'(CARRIER_WAIT_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] DTR_DROP_TICKS = TIMER_W'((DTR_DROP_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [TIMER_W-1:0] BLANK_TICKS = TIMER_W'((BLANK_MS + TICK_MS - 1) / TICK_MS);

  // Register byte offsets
  localparam logic [3:0] MODE_OFS = 4'h0;
  localparam logic [3:0] CMD_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] EVENT_OFS = 4'hC;

  // Mode register fields
  localparam int MODE_W = 6;
  localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
  localparam int ROLE_SELECT_BIT = 3;
  localparam int KEYBOARD_PROMPT_SELECT_BIT = 2;
  localparam int FORCED_DTR_BIT = 1;
  localparam int AUTO_CALL_SELECT_BIT = 0;
  localparam int BAUD_SWITCH_LSB = 4;
  localparam logic [3:0] MODE_FORCED_POOL = 4'h2;

  // Command register bits (write only, self clearing)
  localparam int CMD_OUTBOUND_BIT = 0;
  localparam int CMD_RELEASE_BIT = 1;
  localparam int CMD_AUTOBAUD_DONE_BIT = 2;

  // Event register bits (write one to clear)
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;
  localparam int EV_CARRIER_TIMEOUT_BIT = 0;
  localparam int EV_REMOTE_DISC_BIT = 1;
  localparam int EV_INBOUND_VALID_BIT = 2;

  // Status register bits
  localparam int ST_DTR_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_ACTIVE_BIT = 2;
  localparam int ST_INBOUND_BIT = 3;
  localparam int ST_ESTABLISHED_BIT = 4;
  localparam int ST_AUTOBAUD_BIT = 5;
  localparam int ST_BLANK_BIT = 6;
  localparam int ST_RI_BIT = 7;
  localparam int ST_DCD_BIT = 8;
  localparam int ST_DSR_BIT = 9;
  localparam int ST_DTR_IN_BIT = 10;
  localparam int ST_HOTLINE_BIT = 11;
endpackage

//--- verilog/lead_sequencer.sv
// Control-lead sequencer of a modem-pool data port with Avalon-MM registers
// Notes on behaviour
// R1: In modes 0-3 act as DTE, sample DSR, DCD, RI and drive DTR alone.
// R2: With DCD off in modem modes, no menu output and no echo.
// R3: Prompts and messages enabled on inbound calls, suppressed on outbound calls.
// R4: Modes 0 and 1: DTR off when idle, on while a call is processed.
// R5: Modes 2 and 3: DTR always on, dropped 0.2 s at disconnect of established call.
// R6: Outbound call is answered, DTR raised in modes 0/1, data then passes transparently. Code accepts outbound requests only in modes 0 and 2.
// R7: After establishment, DSR or DCD going off means disconnect.
// R8: RI on starts inbound call: DTR on, busy to outbound in modes 0/1.
// R9: DCD must rise within 35 s of inbound activation, else call dropped.
// R10: DCD before timeout validates inbound call, then await carriage return for autobaud.
// R11: Modem asserts RI while ringing and auto-answers when DTR is on.
// R12: Modem drives DCD on with carrier present and off without it.
// R13: Modem resets its parameters to defaults whenever DTR goes off.
// R14: Mode 1 starts a hotline call at once when RI goes on.
// R15: Mode 1 hotline data rate comes from configuration switches 6 and 8.
// R16: Mode 2 ignores RI and DCD about 2 s after a call is released.
// R17: Mode 15 places hotline calls continuously while DTR is on.
// R18: Mode is four bits: DCE role, keyboard prompt, forced DTR, hotline.
// R19: Intervals timed by a tick counter; reset returns idle with idle DTR level.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module lead_sequencer import lead_seq_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Modem control leads
  input wire logic ri,
  input wire logic dcd,
  input wire logic dsr,
  output logic dtr,
  // Terminal DTR seen in the DCE modes
  input wire logic dtr_in,
  // Call-processing indications
  output logic call_active,
  output logic busy_outbound,
  output logic prompt_enable,
  output logic menu_enable,
  output logic echo_enable,
  output logic data_pass,
  output logic autobaud_wait,
  output logic hotline_call,
  output logic [1:0] baud_select
);
  typedef enum logic [2:0] {
    IDLE,
    RING,
    IN_CALL,
    OUT_CALL,
    DROP,
    BLANK
  } state_type;

  state_type state_q, state_d;
  logic [MODE_W-1:0] mode_q;
  logic [EV_W-1:0] event_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic inbound_q;
  logic est_q;
  logic autobaud_q;
  logic dtr_q, busy_q, active_q, prompt_q, menu_q, echo_q, pass_q, hot_q;
  logic [1:0] baud_q;
  logic timer_start;
  logic [TIMER_W-1:0] timer_limit;
  logic timer_expired;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: one wait state, access taken when waitrequest is low
  wire req = read || write;
  wire accept = req && !wait_q;
  wire wr_mode = accept && write && (address == MODE_OFS);
  wire wr_cmd = accept && write && (address == CMD_OFS);
  wire wr_event = accept && write && (address == EVENT_OFS);
  wire cmd_outbound = wr_cmd && writedata[CMD_OUTBOUND_BIT];
  wire cmd_release = wr_cmd && writedata[CMD_RELEASE_BIT];
  wire cmd_autobaud = wr_cmd && writedata[CMD_AUTOBAUD_DONE_BIT];

  // Mode decode
  wire [3:0] mode = mode_q[3:0];
  wire role_select = mode[ROLE_SELECT_BIT];
  wire keyboard_prompt_select = mode[KEYBOARD_PROMPT_SELECT_BIT];
  wire forced_dtr = mode[FORCED_DTR_BIT];
  wire auto_call_select = mode[AUTO_CALL_SELECT_BIT];
  wire modem_mode = !role_select && !keyboard_prompt_select; // R18
  wire blank_mode = (mode == MODE_FORCED_POOL);
  wire hotline_modem = modem_mode && auto_call_select;
  wire continuous_hotline = role_select && forced_dtr && auto_call_select; // R17

  // Call events
  wire ring_start = modem_mode && ri; // R1
  wire lead_lost = !dcd || !dsr;
  wire remote_disc = est_q && lead_lost; // R7
  wire carrier_timeout = (state_q == RING) && !dcd && timer_expired; // R9
  wire inbound_valid = (state_q == RING) && dcd; // R10
  wire in_call = (state_q == RING) || (state_q == IN_CALL) || (state_q == OUT_CALL);
  wire ends_call = cmd_release || remote_disc || carrier_timeout || !modem_mode;
  wire disc_state = forced_dtr && est_q && modem_mode;
  wire blanking = (state_q == DROP) || (state_q == BLANK);

  // Status word
  wire [31:0] status_word = {20'h00000, hot_q, dtr_in, dsr, dcd, ri, blanking, autobaud_q,
                             est_q, inbound_q, active_q, busy_q, dtr_q};
  wire [31:0] read_mux = (address == MODE_OFS) ? {26'h0, mode_q} :
                         (address == STATUS_OFS) ? status_word :
                         (address == EVENT_OFS) ? {29'h0, event_q} : 32'h00000000;

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign dtr = dtr_q;
  assign call_active = active_q;
  assign busy_outbound = busy_q;
  assign prompt_enable = prompt_q;
  assign menu_enable = menu_q;
  assign echo_enable = echo_q;
  assign data_pass = pass_q;
  assign autobaud_wait = autobaud_q;
  assign hotline_call = hot_q;
  assign baud_select = baud_q;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake and read data, data latched as waitrequest falls
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= !(req && wait_q);
      if (read && wait_q) begin
        rdata_q <= read_mux;
      end
    end
  end

  // Mode register and sticky events; a new event wins over its clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mode_q <= MODE_RESET;
      event_q <= EV_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= writedata[MODE_W-1:0];
      end
      event_q <= (event_q & ~(wr_event ? writedata[EV_W-1:0] : 3'h0)) |
                 {inbound_valid, remote_disc && in_call, carrier_timeout};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Call sequencing and interval timer loads
  always_comb begin
    state_d = state_q;
    timer_start = 1'b0;
    timer_limit = CARRIER_WAIT_TICKS;
    case (state_q)
      IDLE: begin
        if (ring_start) begin
          state_d = RING; // R8
          timer_start = 1'b1; // R9
        end else if (cmd_outbound && modem_mode && !auto_call_select) begin
          state_d = OUT_CALL; // R6
        end
      end
      RING: begin
        if (ends_call) begin
          state_d = IDLE;
        end else if (dcd) begin
          state_d = IN_CALL; // R10
        end
      end
      IN_CALL, OUT_CALL: begin
        if (ends_call && disc_state) begin
          state_d = DROP; // R5
          timer_start = 1'b1;
          timer_limit = DTR_DROP_TICKS; // R19
        end else if (ends_call && blank_mode && modem_mode) begin
          state_d = BLANK; // R16
          timer_start = 1'b1;
          timer_limit = BLANK_TICKS;
        end else if (ends_call) begin
          state_d = IDLE;
        end
      end
      DROP: begin
        if (timer_expired && blank_mode) begin
          state_d = BLANK; // R16
          timer_start = 1'b1;
          timer_limit = BLANK_TICKS;
        end else if (timer_expired) begin
          state_d = IDLE; // R5
        end
      end
      BLANK: begin
        if (timer_expired) begin
          state_d = IDLE; // R16
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
  end

  // State register; reset returns to idle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= IDLE; // R19
    end else begin
      state_q <= state_d;
    end
  end

  // Call direction, establishment and autobaud wait
  always_ff @(posedge mclk) begin
    if (!resetn || state_d == IDLE) begin
      inbound_q <= 1'b0;
      est_q <= 1'b0;
      autobaud_q <= 1'b0;
    end else begin
      if (state_q == IDLE && state_d == RING) begin
        inbound_q <= 1'b1;
      end
      if (state_d == DROP || state_d == BLANK) begin
        est_q <= 1'b0;
      end else if (inbound_valid || (state_q == OUT_CALL && dcd && dsr)) begin
        est_q <= 1'b1; // R7
      end
      if (inbound_valid && state_d == IN_CALL) begin
        autobaud_q <= 1'b1; // R10
      end else if (cmd_autobaud || state_q != IN_CALL) begin
        autobaud_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // DTR level per mode group: forced modes stay on except during the drop
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dtr_q <= MODE_RESET[FORCED_DTR_BIT]; // R19
    end else if (!modem_mode) begin
      dtr_q <= 1'b0; // R1
    end else if (forced_dtr) begin
      dtr_q <= (state_d != DROP); // R5
    end else begin
      dtr_q <= (state_d == RING) || (state_d == IN_CALL) || (state_d == OUT_CALL); // R4
    end
  end

  // Busy to outbound calls while an inbound call runs in modes 0 and 1
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      busy_q <= modem_mode && !forced_dtr && (state_d == RING || state_d == IN_CALL); // R8
      active_q <= (state_d == RING) || (state_d == IN_CALL) || (state_d == OUT_CALL);
    end
  end

  // Message gating: nothing shown or echoed without carrier
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prompt_q <= 1'b0;
      menu_q <= 1'b0;
      echo_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      prompt_q <= dcd && (state_d == IN_CALL); // R3
      menu_q <= dcd && (state_d == IN_CALL); // R2
      echo_q <= dcd && ((state_d == IN_CALL) || (state_d == OUT_CALL)); // R2
      pass_q <= (state_d == OUT_CALL); // R6
    end
  end

  // Hotline requests and hotline data rate
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hot_q <= 1'b0;
      baud_q <= 2'h0;
    end else begin
      hot_q <= (hotline_modem && (state_d == RING || state_d == IN_CALL)) || // R14
               (continuous_hotline && dtr_in); // R17
      baud_q <= hotline_modem ? mode_q[BAUD_SWITCH_LSB +: 2] : 2'h0; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared interval timer for carrier wait, DTR drop and blanking
  interval_timer #(
    .TICK_LEN(TICK_LEN)
  ) timer_u (
    .mclk(mclk),
    .resetn(resetn),
    .start(timer_start),
    .limit(timer_limit),
    .expired(timer_expired)
  );
endmodule // lead_sequencer
